// *** hdl/mcit_consts.svh ***
// Constants for the instruction timing block: byte lengths, cycle counts, opcodes.
// Assumes inclusion by the core file only.
`ifndef MCIT_CONSTS_SVH
`define MCIT_CONSTS_SVH

// Instruction byte lengths
`define MCIT_LEN1 2'h1
`define MCIT_LEN2 2'h2
`define MCIT_LEN3 2'h3

// Execution cycle counts
`define MCIT_CYC1 4'h1
`define MCIT_CYC2 4'h2
`define MCIT_CYC3 4'h3
`define MCIT_CYC_FAR 4'h3
`define MCIT_CYC_MUL 4'h4
`define MCIT_CYC_DIV 4'h8

// Low-nibble operand forms
`define MCIT_LO_IMM 4'h4
`define MCIT_LO_DIR 4'h5
`define MCIT_LO_IND0 4'h6
`define MCIT_LO_IND1 4'h7

// Single opcodes
`define MCIT_OP_MOV_A_IMM 8'h74
`define MCIT_OP_MOV_D_IMM 8'h75
`define MCIT_OP_MOV_D_D 8'h85
`define MCIT_OP_MOV_D_A 8'hf5
`define MCIT_OP_CLR_A 8'he4
`define MCIT_OP_CPL_A 8'hf4
`define MCIT_OP_RL_A 8'h23
`define MCIT_OP_RLC_A 8'h33
`define MCIT_OP_RR_A 8'h03
`define MCIT_OP_RRC_A 8'h13
`define MCIT_OP_SWAP_A 8'hc4
`define MCIT_OP_DA_A 8'hd4
`define MCIT_OP_INC_PTR 8'ha3
`define MCIT_OP_MUL 8'ha4
`define MCIT_OP_DIV 8'h84

`endif

// *** hdl/mcit_pkg.sv ***
// Types for the instruction timing block.
// Assumes the constants header sits beside it.
package mcit_pkg;

  typedef enum logic {MCIT_IDLE, MCIT_BUSY} mcit_state_type;

  typedef enum logic [2:0] {
    MCIT_G_NONE, MCIT_G_ARITH, MCIT_G_LOGIC, MCIT_G_ACC, MCIT_G_MOVE,
    MCIT_G_INCDEC, MCIT_G_MULDIV, MCIT_G_FAR
  } mcit_group_type;

  typedef enum logic [2:0] {
    MCIT_M_NONE, MCIT_M_REG, MCIT_M_DIR, MCIT_M_IND, MCIT_M_IMM, MCIT_M_ACC
  } mcit_mode_type;

  typedef struct packed {
    logic known;
    logic [1:0] len;
    logic [3:0] cyc;
    mcit_group_type group;
    mcit_mode_type mode;
    logic far_rd;
    logic far_wr;
  } mcit_decode_type;

  typedef struct packed {
    mcit_state_type state;
    logic [3:0] cnt;
    logic [7:0] opcode;
    mcit_decode_type info;
    logic done;
    logic flash_rd;
    logic flash_wr;
    logic [15:0] pc;
  } mcit_regs_type;

endpackage : mcit_pkg

// *** hdl/mcit_core_timing.sv ***
// Instruction decode and execution timing for the arithmetic, logic and move groups.
// Assumes opcodes arrive from on-chip flash, synchronous to clk_sys.
//
// Functional notes
// [RULE1] Every far space move, read or write, targets on-chip flash program memory.
// [RULE2] No off-chip data or program memory port; all accesses stay on chip.
// [RULE3] Add and add-with-carry: register 1/1, direct or immediate 2/2, indirect 2 cycles 1 byte.
// [RULE4] Subtract with borrow: register 1/1, indirect 2 cycles 1 byte, direct or immediate 2/2.
// [RULE5] AND, OR, XOR into accumulator: register 1/1, indirect 2c/1b, direct/immediate 2/2.
// [RULE6] AND, OR, XOR into direct byte: accumulator source 2/2, immediate source 3/3.
// [RULE7] Clear, complement, rotates and nibble swap of accumulator finish in one cycle.
// [RULE8] Move to accumulator: register 1/1, indirect 2c/1b, direct or immediate 2/2.
// [RULE9] Move to working register: from accumulator 1/1, from direct or immediate 2/2.
// [RULE10] Move to direct: from accumulator, register, indirect 2/2; direct or immediate 3/3.
// [RULE11] Move to indirect RAM: from accumulator 2c/1b, from direct or immediate 2/2.
// [RULE12] Increment/decrement: acc or register 1/1, direct 2/2, indirect 2c/1b; pointer 1.
// [RULE13] Multiply four cycles, divide eight cycles, decimal adjust one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "mcit_consts.svh"

module mcit_core_timing (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic op_valid,
  input wire logic [7:0] op_byte,
  output logic op_ready,
  output logic done,
  output logic [7:0] opcode,
  output mcit_pkg::mcit_decode_type info,
  output logic flash_rd,
  output logic flash_wr,
  output logic [15:0] pc
);
  import mcit_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic mcit_decode_type mcit_lc(
    input logic [1:0] len,
    input logic [3:0] cyc,
    input mcit_group_type group,
    input mcit_mode_type mode
  );
    mcit_decode_type d;
    d = '0;
    d.known = 1'b1;
    d.len = len;
    d.cyc = cyc;
    d.group = group;
    d.mode = mode;
    return d;
  endfunction : mcit_lc

  // Source operand forms shared by the arithmetic, logic, move and inc/dec groups
  function automatic mcit_decode_type mcit_src(
    input logic [3:0] lo,
    input logic acc_slot,
    input mcit_group_type group
  );
    mcit_decode_type d;
    d = '0;
    if (lo == `MCIT_LO_IMM)
    begin
      if (acc_slot)
      begin
        d = mcit_lc(`MCIT_LEN1, `MCIT_CYC1, group, MCIT_M_ACC); // [RULE12]
      end
      else
      begin
        d = mcit_lc(`MCIT_LEN2, `MCIT_CYC2, group, MCIT_M_IMM); // [RULE3] [RULE4] [RULE5]
      end
    end
    else if (lo == `MCIT_LO_DIR)
    begin
      d = mcit_lc(`MCIT_LEN2, `MCIT_CYC2, group, MCIT_M_DIR); // [RULE3] [RULE4] [RULE5] [RULE8]
    end
    else if (lo == `MCIT_LO_IND0 || lo == `MCIT_LO_IND1)
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC2, group, MCIT_M_IND); // [RULE3] [RULE4] [RULE5] [RULE8]
    end
    else if (lo[3])
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC1, group, MCIT_M_REG); // [RULE3] [RULE4] [RULE5] [RULE8]
    end
    return d;
  endfunction : mcit_src

  function automatic mcit_decode_type mcit_decode(input logic [7:0] op);
    mcit_decode_type d;
    logic [3:0] hi;
    logic [3:0] lo;
    logic ind;
    hi = op[7:4];
    lo = op[3:0];
    ind = (lo == `MCIT_LO_IND0 || lo == `MCIT_LO_IND1);
    d = '0;
    // Far moves always land in on-chip flash; no off-chip strobe exists
    if (op == 8'he0 || op == 8'he2 || op == 8'he3)
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC_FAR, MCIT_G_FAR, MCIT_M_IND);
      d.far_rd = 1'b1; // [RULE1] [RULE2]
    end
    else if (op == 8'hf0 || op == 8'hf2 || op == 8'hf3)
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC_FAR, MCIT_G_FAR, MCIT_M_IND);
      d.far_wr = 1'b1; // [RULE1] [RULE2]
    end
    else if (op == `MCIT_OP_CLR_A || op == `MCIT_OP_CPL_A || op == `MCIT_OP_RL_A ||
             op == `MCIT_OP_RLC_A || op == `MCIT_OP_RR_A || op == `MCIT_OP_RRC_A ||
             op == `MCIT_OP_SWAP_A)
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC1, MCIT_G_ACC, MCIT_M_ACC); // [RULE7]
    end
    else if (op == `MCIT_OP_DA_A)
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC1, MCIT_G_ARITH, MCIT_M_ACC); // [RULE13]
    end
    else if (op == `MCIT_OP_MUL)
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC_MUL, MCIT_G_MULDIV, MCIT_M_ACC); // [RULE13]
    end
    else if (op == `MCIT_OP_DIV)
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC_DIV, MCIT_G_MULDIV, MCIT_M_ACC); // [RULE13]
    end
    else if (op == `MCIT_OP_INC_PTR)
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC1, MCIT_G_INCDEC, MCIT_M_NONE); // [RULE12]
    end
    else if (op == `MCIT_OP_MOV_A_IMM)
    begin
      d = mcit_lc(`MCIT_LEN2, `MCIT_CYC2, MCIT_G_MOVE, MCIT_M_IMM); // [RULE8]
    end
    else if (op == `MCIT_OP_MOV_D_IMM || op == `MCIT_OP_MOV_D_D)
    begin
      d = mcit_lc(`MCIT_LEN3, `MCIT_CYC3, MCIT_G_MOVE, MCIT_M_DIR); // [RULE10]
    end
    else if (op == `MCIT_OP_MOV_D_A)
    begin
      d = mcit_lc(`MCIT_LEN2, `MCIT_CYC2, MCIT_G_MOVE, MCIT_M_ACC); // [RULE10]
    end
    else if ((hi == 4'h4 || hi == 4'h5 || hi == 4'h6) && lo == 4'h2)
    begin
      d = mcit_lc(`MCIT_LEN2, `MCIT_CYC2, MCIT_G_LOGIC, MCIT_M_ACC); // [RULE6]
    end
    else if ((hi == 4'h4 || hi == 4'h5 || hi == 4'h6) && lo == 4'h3)
    begin
      d = mcit_lc(`MCIT_LEN3, `MCIT_CYC3, MCIT_G_LOGIC, MCIT_M_IMM); // [RULE6]
    end
    else if ((hi == 4'h2 || hi == 4'h3 || hi == 4'h9) && lo >= `MCIT_LO_IMM)
    begin
      d = mcit_src(lo, 1'b0, MCIT_G_ARITH); // [RULE3] [RULE4]
    end
    else if ((hi == 4'h4 || hi == 4'h5 || hi == 4'h6) && lo >= `MCIT_LO_IMM)
    begin
      d = mcit_src(lo, 1'b0, MCIT_G_LOGIC); // [RULE5]
    end
    else if (hi == 4'he && lo >= `MCIT_LO_DIR)
    begin
      d = mcit_src(lo, 1'b0, MCIT_G_MOVE); // [RULE8]
    end
    else if ((hi == 4'h0 || hi == 4'h1) && lo >= `MCIT_LO_IMM)
    begin
      d = mcit_src(lo, 1'b1, MCIT_G_INCDEC); // [RULE12]
    end
    else if (hi == 4'hf && ind)
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC2, MCIT_G_MOVE, MCIT_M_ACC); // [RULE11]
    end
    else if ((hi == 4'ha || hi == 4'h7) && ind)
    begin
      d = mcit_lc(`MCIT_LEN2, `MCIT_CYC2, MCIT_G_MOVE, MCIT_M_IND); // [RULE11]
    end
    else if (hi == 4'h8 && (ind || lo[3]))
    begin
      d = mcit_lc(`MCIT_LEN2, `MCIT_CYC2, MCIT_G_MOVE, MCIT_M_DIR); // [RULE10]
    end
    else if (hi == 4'hf && lo[3])
    begin
      d = mcit_lc(`MCIT_LEN1, `MCIT_CYC1, MCIT_G_MOVE, MCIT_M_REG); // [RULE9]
    end
    else if ((hi == 4'ha || hi == 4'h7) && lo[3])
    begin
      d = mcit_lc(`MCIT_LEN2, `MCIT_CYC2, MCIT_G_MOVE, MCIT_M_REG); // [RULE9]
    end
    else
    begin
      // Outside the decoded groups: one byte, one cycle, flagged unknown
      d.len = `MCIT_LEN1;
      d.cyc = `MCIT_CYC1;
    end
    return d;
  endfunction : mcit_decode

  ////////////////////////////////////////////////////////////////////////////////
  // State

  mcit_regs_type s_reg;
  mcit_regs_type s_next;
  mcit_decode_type dec;
  logic accept;

  assign dec = mcit_decode(op_byte);
  assign op_ready = (s_reg.state == MCIT_IDLE);
  assign accept = op_valid && op_ready;

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.flash_rd = 1'b0;
    s_next.flash_wr = 1'b0;
    case (s_reg.state)
      MCIT_IDLE:
      begin
        if (accept)
        begin
          s_next.opcode = op_byte;
          s_next.info = dec;
          s_next.pc = s_reg.pc + {14'h0000, dec.len};
          s_next.flash_rd = dec.far_rd; // [RULE1]
          s_next.flash_wr = dec.far_wr; // [RULE1]
          s_next.cnt = dec.cyc - 4'h1;
          if (dec.cyc == `MCIT_CYC1)
          begin
            s_next.done = 1'b1;
          end
          else
          begin
            s_next.state = MCIT_BUSY;
          end
        end
      end
      MCIT_BUSY:
      begin
        s_next.cnt = s_reg.cnt - 4'h1;
        if (s_reg.cnt == 4'h1)
        begin
          s_next.state = MCIT_IDLE;
          s_next.done = 1'b1;
        end
      end
      default:
      begin
        s_next.state = MCIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign done = s_reg.done;
  assign opcode = s_reg.opcode;
  assign info = s_reg.info;
  assign flash_rd = s_reg.flash_rd;
  assign flash_wr = s_reg.flash_wr;
  assign pc = s_reg.pc;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_far_write_flash: assert property (accept && op_byte == 8'hf0 |=> flash_wr // [RULE1]
    && !flash_rd && info.len == `MCIT_LEN1 && !op_ready ##2 done)
    else $error("far write timing");
  a_far_read_flash: assert property (accept && op_byte == 8'he0 |=> flash_rd // [RULE2]
    && !flash_wr && !op_ready ##2 done)
    else $error("far read timing");
  a_add_reg_one: assert property (accept && op_byte == 8'h28 |=> done && op_ready // [RULE3]
    && info.len == `MCIT_LEN1) else $error("add register timing");
  a_subb_ind_two: assert property (accept && op_byte == 8'h96 |=> !op_ready // [RULE4]
    && info.len == `MCIT_LEN1 ##1 done && op_ready) else $error("subb indirect");
  a_xrl_direct_two: assert property (accept && op_byte == 8'h65 |=> !done // [RULE5]
    && info.len == `MCIT_LEN2 ##1 done) else $error("xrl direct timing");
  a_anl_dir_imm: assert property (accept && op_byte == 8'h53 |=> (!op_ready)[*2] // [RULE6]
    ##1 done && info.len == `MCIT_LEN3) else $error("anl direct immediate");
  a_swap_one: assert property (accept && op_byte == 8'hc4 |=> done && op_ready) // [RULE7]
    else $error("swap timing");
  a_mov_a_ind: assert property (accept && op_byte == 8'he7 |=> !op_ready // [RULE8]
    && info.len == `MCIT_LEN1 ##1 done) else $error("mov a indirect");
  a_mov_r_imm: assert property (accept && op_byte == 8'h7b |=> info.len == `MCIT_LEN2 // [RULE9]
    ##1 done) else $error("mov register immediate");
  a_mov_dir_dir: assert property (accept && op_byte == 8'h85 |=> (!done)[*2] // [RULE10]
    ##1 done && pc == $past(pc, 3) + 16'h0003) else $error("mov direct direct");
  a_mov_ind_acc: assert property (accept && op_byte == 8'hf6 |=> info.len == `MCIT_LEN1 // [RULE11]
    && !done ##1 done) else $error("mov indirect accumulator");
  a_inc_ind_two: assert property (accept && op_byte == 8'h06 |=> !op_ready ##1 op_ready) // [RULE12]
    else $error("inc indirect timing");
  a_div_eight: assert property (accept && op_byte == 8'h84 |=> (!op_ready)[*7] ##1 done) // [RULE13]
    else $error("divide timing");

endmodule : mcit_core_timing

`default_nettype wire

// *** tb/mcit_flash_model.sv ***
// Opcode feed model standing in for on-chip flash.
// Assumes the bench calls offer and idle; drives at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module mcit_flash_model (
  input wire logic clk_sys,
  input wire logic op_ready,
  input wire logic flash_rd,
  input wire logic flash_wr,
  output logic op_valid,
  output logic [7:0] op_byte
);
  logic [7:0] cur = 8'h00;
  logic [7:0] noise = 8'h5a;
  int rd_cnt = 0;
  int wr_cnt = 0;
  initial op_valid = 1'b0;
  // Released bus shows a changing pattern
  assign op_byte = op_valid ? cur : noise;
  always @(negedge clk_sys) noise <= noise + 8'h3b;
  // Far space strobes land here only
  always @(posedge clk_sys)
  begin
    if (flash_rd === 1'b1) rd_cnt++;
    if (flash_wr === 1'b1) wr_cnt++;
  end
  // Offer a byte and hold it until the taking edge
  task automatic offer(input logic [7:0] b, input int gap);
    int n;
    n = 0;
    repeat (gap) @(negedge clk_sys);
    @(negedge clk_sys);
    op_valid <= 1'b1;
    cur <= b;
    while (op_ready !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
  endtask : offer
  task automatic idle();
    @(negedge clk_sys);
    op_valid <= 1'b0;
  endtask : idle
endmodule : mcit_flash_model
`default_nettype wire

// *** tb/mcit_core_timing_test.sv ***
// Self-checking bench for the instruction timing block.
// Assumes the feed model beside it; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module mcit_core_timing_test;
  import mcit_pkg::*;
  logic clk_sys;
  logic reset_n;
  logic op_valid;
  logic op_ready;
  logic done;
  logic flash_rd;
  logic flash_wr;
  logic [7:0] op_byte;
  logic [7:0] opcode;
  logic [15:0] pc;
  mcit_decode_type info;
  int error_cnt = 0;
  int samples_checked = 0;
  logic [15:0] exp_pc = 16'h0000;
  // Rows: opcode, bytes, cycles
  logic [15:0] rows [72] = '{
    16'h2811, 16'h2522, 16'h2612, 16'h2422, 16'h3811, 16'h3522, 16'h3612, 16'h3422,
    16'h9811, 16'h9612, 16'h9522, 16'h9422, 16'h5811, 16'h5612, 16'h5522, 16'h5422,
    16'h4811, 16'h4612, 16'h4522, 16'h4422, 16'h6811, 16'h6612, 16'h6522, 16'h6422,
    16'h5222, 16'h5333, 16'h4222, 16'h4333, 16'h6222, 16'h6333, 16'he411, 16'hf411,
    16'h2311, 16'h0311, 16'h3311, 16'h1311, 16'hc411, 16'he811, 16'he612, 16'he522,
    16'h7422, 16'hf811, 16'ha822, 16'h7822, 16'hf522, 16'h8822, 16'h8622, 16'h8533,
    16'h7533, 16'hf612, 16'ha622, 16'h7622, 16'h0411, 16'h0811, 16'h0522, 16'h0612,
    16'h1411, 16'h1811, 16'h1522, 16'h1612, 16'ha311, 16'ha414, 16'h8418, 16'hd411,
    16'he013, 16'he213, 16'he313, 16'hf013, 16'hf213, 16'hf313, 16'he712, 16'h7b22};
  mcit_core_timing dut_u (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .op_valid(op_valid),
    .op_byte(op_byte),
    .op_ready(op_ready),
    .done(done),
    .opcode(opcode),
    .info(info),
    .flash_rd(flash_rd),
    .flash_wr(flash_wr),
    .pc(pc));
  mcit_flash_model fm_u (
    .clk_sys(clk_sys),
    .op_ready(op_ready),
    .flash_rd(flash_rd),
    .flash_wr(flash_wr),
    .op_valid(op_valid),
    .op_byte(op_byte));
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // Two takes back to back, spacing in cycles
  task automatic pair(input logic [7:0] a, b, input logic [3:0] la, lb, input int n, nb);
    time t0;
    fm_u.offer(a, 0);
    t0 = $time;
    fm_u.offer(b, 0);
    check($time - t0, n * 100);
    exp_pc = exp_pc + la + lb;
    fm_u.idle();
    check(done, nb == 1);
    check(pc, exp_pc);
    repeat (10) @(negedge clk_sys);
  endtask : pair
  // Watchdog well past the expected run of under a thousand cycles
  initial
  begin
    #500000;
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    logic [15:0] r;
    int k;
    reset_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check(op_ready, 1'b1);
    check(done, 1'b0);
    check(pc, 16'h0000);
    check(info, 16'h0000);
    reset_n <= 1'b1;
    foreach (rows[i])
    begin
      r = rows[i];
      fm_u.offer(r[15:8], i % 3);
      exp_pc = exp_pc + r[7:4];
      fm_u.idle();
      check(opcode, r[15:8]);
      check(info.len, r[7:4]);
      check(info.cyc, r[3:0]);
      check(info.known, 1'b1);
      check(pc, exp_pc);
      check(flash_rd, r[15:8] inside {8'he0, 8'he2, 8'he3});
      check(flash_wr, r[15:8] inside {8'hf0, 8'hf2, 8'hf3});
      check(op_ready, r[3:0] == 4'h1);
      k = 1;
      while (done !== 1'b1 && k < 12)
      begin
        @(negedge clk_sys);
        k++;
      end
      check(k, r[3:0]);
    end
    pair(8'h85, 8'h28, 4'h3, 4'h1, 3, 1);
    pair(8'h84, 8'he4, 4'h1, 4'h1, 8, 1);
    pair(8'he0, 8'hf0, 4'h1, 4'h1, 3, 3);
    fm_u.offer(8'h84, 0);
    fm_u.idle();
    reset_n <= 1'b0;
    @(negedge clk_sys);
    reset_n <= 1'b1;
    check(op_ready, 1'b1);
    check(pc, 16'h0000);
    check(done, 1'b0);
    check(opcode, 8'h00);
    exp_pc = 16'h0000;
    fm_u.offer(8'h80, 0);
    fm_u.idle();
    check(info.known, 1'b0);
    check(info.cyc, 4'h1);
    check(pc, 16'h0001);
    check(fm_u.rd_cnt, 16'h0004);
    check(fm_u.wr_cnt, 16'h0004);
    report_and_stop();
  end
endmodule : mcit_core_timing_test
`default_nettype wire
